// ==== pkg/rcd_pkg.sv ====
package rcd_pkg;
   // Counter and decoder geometry
   localparam int CNT_W = 5;
   localparam int SEL_W = 4;
   localparam int HALF_LINES = 16;
   localparam int NUM_HALVES = 2;
   localparam int NUM_CMD = 32;
   localparam int NUM_RELAY = 16;
   // Input pin indices in the synchronised control vector
   localparam int IDX_UP = 0;
   localparam int IDX_DOWN = 1;
   localparam int IDX_EXEC = 2;
   localparam int IDX_PWR_ON = 3;
   localparam int IDX_PWR_OFF = 4;
   localparam int IDX_HTR_ON = 5;
   localparam int IDX_HTR_OFF = 6;
   localparam int IDX_STOP = 7;
   localparam int IDX_GATE = 8;
   localparam int NUM_CTRL = 9;
   // Stage counts
   localparam int SYNC_STAGES = 2;
   localparam int GATE_STAGES = 6;
   localparam int DEF_BUF_W = 4;
   localparam int NUM_DIRECT = 2;
   // Reset values
   localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
   localparam logic DIR_UP = 1'b1;
   localparam logic DIR_DOWN = 1'b0;
   localparam logic DIR_RST = 1'b1;
   localparam logic [NUM_CMD-1:0] CMD_IDLE_N = 32'hFFFF_FFFF;
   localparam logic [HALF_LINES-1:0] HALF_IDLE_N = 16'hFFFF;
   // Default command assignments
   localparam logic [CNT_W-1:0] DEF_PT_LINE = 5'h01;
   localparam logic [NUM_RELAY-1:0] DEF_RELAY_MASK = 16'hFF00;
   typedef logic [CNT_W-1:0] rcd_cnt_t;
endpackage : rcd_pkg

// ==== pkg/rcd_dec_if.sv ====
`timescale 1ns/100ps
interface rcd_dec_if;
   import rcd_pkg::*;
   logic [SEL_W-1:0] sel;
   logic en;
   logic [HALF_LINES-1:0] line_n;
   modport dec (input sel, input en, output line_n);
   modport ctl (output sel, output en, input line_n);
endinterface : rcd_dec_if

// ==== src/rcd_dec16.sv ====
`timescale 1ns/100ps
module rcd_dec16
(
   rcd_dec_if.dec dif
);
   import rcd_pkg::*;

   // One active-low line when enabled, none otherwise
   always_comb
   begin
      dif.line_n = HALF_IDLE_N;
      if (dif.en)
      begin
         dif.line_n[dif.sel] = 1'b0;
      end
   end
endmodule : rcd_dec16

// ==== src/rcd_relay_drv.sv ====
`timescale 1ns/100ps
module rcd_relay_drv
#(
   parameter int N = 1
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [N-1:0] on_n,
   input wire logic [N-1:0] off_n,
   output logic [N-1:0] on_drv,
   output logic [N-1:0] off_drv
);
   import rcd_pkg::*;

   logic [N-1:0] on_req;
   logic [N-1:0] off_req;

   // Inverting gate ahead of each driver
   assign on_req = ~on_n;
   assign off_req = ~off_n;

   // Separate coil drives, conflicting requests drive neither coil
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         on_drv <= '0;
         off_drv <= '0;
      end
      else
      begin
         on_drv <= on_req & ~off_req;
         off_drv <= off_req & ~on_req;
      end
   end
endmodule : rcd_relay_drv

// ==== src/rcd_cmd_top.sv ====
`timescale 1ns/100ps
module rcd_cmd_top
#(
   parameter int BUF_W = rcd_pkg::DEF_BUF_W,
   parameter logic [rcd_pkg::CNT_W-1:0] PT_LINE = rcd_pkg::DEF_PT_LINE,
   parameter logic [rcd_pkg::NUM_RELAY-1:0] RELAY_MASK = rcd_pkg::DEF_RELAY_MASK
)
(
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire logic CMD_UP,
   input wire logic CMD_DOWN,
   input wire logic CMD_EXEC,
   input wire logic DEC_PWR_ON,
   input wire logic DEC_PWR_OFF,
   input wire logic HTR_ON,
   input wire logic HTR_OFF,
   input wire logic STOP_ALL_MOTORS,
   input wire logic DATA_GATE,
   input wire logic [BUF_W-1:0] BUF_IN,
   output logic [BUF_W-1:0] BUF_OUT,
   output logic DATA_GATE_DLY,
   output rcd_pkg::rcd_cnt_t COUNT_STATUS,
   output logic DIR_STATUS,
   output logic [rcd_pkg::NUM_CMD-1:0] LOGIC_CMD_N,
   output logic [rcd_pkg::NUM_RELAY-1:0] RLY_ON_DRV,
   output logic [rcd_pkg::NUM_RELAY-1:0] RLY_OFF_DRV,
   output logic HTR_ON_DRV,
   output logic HTR_OFF_DRV,
   output logic DEC_ON_DRV,
   output logic DEC_OFF_DRV,
   output logic PRES_XDCR_ON
);
   import rcd_pkg::*;

   localparam int NUM_IN = NUM_CTRL + BUF_W;

   // Pin synchronisers
   logic [NUM_IN-1:0] pin_raw;
   logic [NUM_IN-1:0] meta_ff;
   logic [NUM_IN-1:0] sync_ff;

   // Two inverting buffer stages
   logic [NUM_IN-1:0] inv1_ff;
   logic [NUM_IN-1:0] inv2_ff;
   logic [NUM_IN-1:0] prev_ff;

   // Data gate delay chain
   logic [GATE_STAGES-1:0] gate_ff;

   // Counter state
   rcd_cnt_t cnt_ff;
   rcd_cnt_t nxt_cnt;
   logic [CNT_W-1:0] tog;
   logic dir_ff;
   logic nxt_dir;

   // Command edges and levels
   logic up_rise;
   logic dn_rise;
   logic count_clk;
   logic pwr_rise;
   logic stop_rise;
   logic exec_lvl;

   // Decoder outputs
   logic [NUM_CMD-1:0] dec_lines_n;
   logic [NUM_RELAY-1:0] rly_on_n;
   logic [NUM_RELAY-1:0] rly_off_n;
   logic [NUM_CMD-1:0] cmd_ff;

   // Direct station commands into relay drivers
   logic [NUM_DIRECT-1:0] dir_on_n;
   logic [NUM_DIRECT-1:0] dir_off_n;
   logic [NUM_DIRECT-1:0] dir_on_drv;
   logic [NUM_DIRECT-1:0] dir_off_drv;

   // Transducer state
   logic pt_ff;
   logic pt_hit;
   logic pt_prev_ff;

   assign pin_raw = {BUF_IN,
                     DATA_GATE,
                     STOP_ALL_MOTORS,
                     HTR_OFF,
                     HTR_ON,
                     DEC_PWR_OFF,
                     DEC_PWR_ON,
                     CMD_EXEC,
                     CMD_DOWN,
                     CMD_UP};

   // Two-flop synchronisers on every pin
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= pin_raw;
         sync_ff <= meta_ff;
      end
   end

   // Buffer stages, each inverting
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         inv1_ff <= '1;
         inv2_ff <= '0;
      end
      else
      begin
         inv1_ff <= ~sync_ff;
         inv2_ff <= ~inv1_ff;
      end
   end

   // Previous buffered levels for edge detection
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         prev_ff <= '0;
      end
      else
      begin
         prev_ff <= inv2_ff;
      end
   end

   assign BUF_OUT = inv2_ff[NUM_IN-1:NUM_CTRL];

   // Data gate through six inverting stages
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         // Idle chain pattern for a low gate, so no false gate after reset
         gate_ff <= {(GATE_STAGES / 2){2'b01}};
      end
      else
      begin
         gate_ff[0] <= ~sync_ff[IDX_GATE];
         for (int i = 1; i < GATE_STAGES; i++)
         begin
            gate_ff[i] <= ~gate_ff[i-1];
         end
      end
   end

   assign DATA_GATE_DLY = gate_ff[GATE_STAGES-1];

   // Command edges
   assign up_rise = inv2_ff[IDX_UP] & ~prev_ff[IDX_UP];
   assign dn_rise = inv2_ff[IDX_DOWN] & ~prev_ff[IDX_DOWN];
   assign pwr_rise = inv2_ff[IDX_PWR_ON] & ~prev_ff[IDX_PWR_ON];
   assign stop_rise = inv2_ff[IDX_STOP] & ~prev_ff[IDX_STOP];
   assign exec_lvl = inv2_ff[IDX_EXEC];

   // Single counting clock from either command
   assign count_clk = up_rise | dn_rise;

   // Direction latch, up taking priority when both arrive together
   always_comb
   begin
      nxt_dir = dir_ff;
      if (up_rise)
      begin
         nxt_dir = DIR_UP;
      end
      else if (dn_rise)
      begin
         nxt_dir = DIR_DOWN;
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         dir_ff <= DIR_RST;
      end
      else
      begin
         dir_ff <= nxt_dir;
      end
   end

   assign DIR_STATUS = dir_ff;

   // Toggle enables of the reversible counter
   assign tog[0] = 1'b1;
   generate
      for (genvar b = 1; b < CNT_W; b++)
      begin : g_tog
         assign tog[b] = tog[b-1] & (cnt_ff[b-1] == nxt_dir);
      end
   endgenerate

   // Five toggle stages, natural wrap at both ends
   assign nxt_cnt = cnt_ff ^ tog;

   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         cnt_ff <= CNT_RST;
      end
      else if (pwr_rise)
      begin
         cnt_ff <= CNT_RST;
      end
      else if (count_clk)
      begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign COUNT_STATUS = cnt_ff;

   // Two sixteen-line decoder halves
   generate
      for (genvar h = 0; h < NUM_HALVES; h++)
      begin : g_half
         rcd_dec_if dif ();
         assign dif.sel = cnt_ff[SEL_W-1:0];
         assign dif.en = exec_lvl & (cnt_ff[CNT_W-1] == 1'(h));
         assign dec_lines_n[h*HALF_LINES +: HALF_LINES] = dif.line_n;
         rcd_dec16 u_dec
         (
            .dif (dif.dec)
         );
      end
   endgenerate

   // Logic commands registered one cycle after the decoder, active low
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         cmd_ff <= CMD_IDLE_N;
      end
      else
      begin
         cmd_ff <= dec_lines_n;
      end
   end

   assign LOGIC_CMD_N = cmd_ff;

   // Relay lines: even line drives on, odd line drives off, only for relays whose RELAY_MASK bit is set
   generate
      for (genvar r = 0; r < NUM_RELAY; r++)
      begin : g_rly
         assign rly_on_n[r] = dec_lines_n[2*r] | ~RELAY_MASK[r];
         assign rly_off_n[r] = dec_lines_n[2*r+1] | ~RELAY_MASK[r];
      end
   endgenerate

   rcd_relay_drv
   #(
      .N (NUM_RELAY)
   )
   u_cmd_rly
   (
      .clk (REF_CLK),
      .rst_n (NRST),
      .on_n (rly_on_n),
      .off_n (rly_off_n),
      .on_drv (RLY_ON_DRV),
      .off_drv (RLY_OFF_DRV)
   );

   // Direct station commands: heater and decoder power
   assign dir_on_n = ~{inv2_ff[IDX_PWR_ON], inv2_ff[IDX_HTR_ON]};
   assign dir_off_n = ~{inv2_ff[IDX_PWR_OFF], inv2_ff[IDX_HTR_OFF]};

   rcd_relay_drv
   #(
      .N (NUM_DIRECT)
   )
   u_dir_rly
   (
      .clk (REF_CLK),
      .rst_n (NRST),
      .on_n (dir_on_n),
      .off_n (dir_off_n),
      .on_drv (dir_on_drv),
      .off_drv (dir_off_drv)
   );

   assign HTR_ON_DRV = dir_on_drv[0];
   assign HTR_OFF_DRV = dir_off_drv[0];
   assign DEC_ON_DRV = dir_on_drv[1];
   assign DEC_OFF_DRV = dir_off_drv[1];

   // Pressure transducer: on by its counter command, off by stop-all-motors
   assign pt_hit = ~dec_lines_n[PT_LINE];

   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         pt_prev_ff <= 1'b0;
      end
      else
      begin
         pt_prev_ff <= pt_hit;
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         pt_ff <= 1'b0;
      end
      else if (pt_hit & ~pt_prev_ff)
      begin
         pt_ff <= 1'b1;
      end
      else if (stop_rise)
      begin
         pt_ff <= 1'b0;
      end
   end

   assign PRES_XDCR_ON = pt_ff;
endmodule : rcd_cmd_top

// ==== bench/rcd_cmd_properties.sv ====
`timescale 1ns/100ps
module rcd_cmd_checker
#(
   parameter int BUF_W = 4
)
(
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire logic CMD_UP,
   input wire logic CMD_DOWN,
   input wire logic CMD_EXEC,
   input wire logic DEC_PWR_ON,
   input wire logic DATA_GATE,
   input wire logic [BUF_W-1:0] BUF_IN,
   input wire logic [BUF_W-1:0] BUF_OUT,
   input wire logic DATA_GATE_DLY,
   input wire rcd_pkg::rcd_cnt_t COUNT_STATUS,
   input wire logic DIR_STATUS,
   input wire logic [rcd_pkg::NUM_CMD-1:0] LOGIC_CMD_N
);
   import rcd_pkg::*;
   logic [3:0] qm_ff;
   logic [3:0] qe_ff;
   logic [3:0] run_ff;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   // Cycles without any counter command
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST || CMD_UP || CMD_DOWN || DEC_PWR_ON)
         qm_ff <= 4'h0;
      else if (qm_ff != 4'hF)
         qm_ff <= qm_ff + 4'h1;
   end
   // Cycles without execute
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST || CMD_EXEC)
         qe_ff <= 4'h0;
      else if (qe_ff != 4'hF)
         qe_ff <= qe_ff + 4'h1;
   end
   // Cycles since reset release
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
         run_ff <= 4'h0;
      else if (run_ff != 4'hF)
         run_ff <= run_ff + 4'h1;
   end
   a_count_one_step: assert property (
      $changed(COUNT_STATUS) && !(COUNT_STATUS == CNT_RST && $past(DEC_PWR_ON, 5)) |->
      COUNT_STATUS == $past(COUNT_STATUS) + (DIR_STATUS ? 5'h01 : 5'h1F))
      else $error("counter moved by other than one step");
   a_count_holds: assert property (
      qm_ff >= 4'h7 |-> $stable(COUNT_STATUS))
      else $error("counter moved without a command");
   a_exec_gates: assert property (
      qe_ff >= 4'h7 |-> LOGIC_CMD_N == CMD_IDLE_N)
      else $error("command line active without execute");
   a_line_select: assert property (
      (CMD_EXEC && $stable(COUNT_STATUS)) [*6] |->
      LOGIC_CMD_N == ~(32'h1 << COUNT_STATUS))
      else $error("wrong command line selected");
   a_dir_up: assert property (
      $rose(CMD_UP) |-> ##[3:5] DIR_STATUS)
      else $error("direction not set to up");
   a_pwr_clears: assert property (
      $rose(DEC_PWR_ON) |-> ##[3:6] COUNT_STATUS == CNT_RST)
      else $error("counter not cleared by power on");
   a_buf_delay: assert property (
      run_ff == 4'hF |-> BUF_OUT == $past(BUF_IN, 4))
      else $error("buffered signal wrong");
   a_gate_delay: assert property (
      run_ff == 4'hF |-> DATA_GATE_DLY == $past(DATA_GATE, 8))
      else $error("data gate delay wrong");
endmodule : rcd_cmd_checker
bind rcd_cmd_top rcd_cmd_checker #(.BUF_W(BUF_W)) i_chk
(
   .REF_CLK(REF_CLK),
   .NRST(NRST),
   .CMD_UP(CMD_UP),
   .CMD_DOWN(CMD_DOWN),
   .CMD_EXEC(CMD_EXEC),
   .DEC_PWR_ON(DEC_PWR_ON),
   .DATA_GATE(DATA_GATE),
   .BUF_IN(BUF_IN),
   .BUF_OUT(BUF_OUT),
   .DATA_GATE_DLY(DATA_GATE_DLY),
   .COUNT_STATUS(COUNT_STATUS),
   .DIR_STATUS(DIR_STATUS),
   .LOGIC_CMD_N(LOGIC_CMD_N)
);

// ==== bench/rcd_station.sv ====
`timescale 1ns/100ps
module rcd_station
(
   input wire logic clk,
   output logic [rcd_pkg::NUM_CTRL-1:0] cmd,
   output logic [3:0] bufv
);
   import rcd_pkg::*;
   initial
   begin
      cmd = '0;
      bufv = 4'h0;
   end
   // Level change, then settle; every pin, execute included, held six cycles
   task automatic set(input int i, input logic v);
      @(posedge clk);
      cmd[i] <= v;
      repeat (6) @(posedge clk);
   endtask : set
   task automatic pulse(input int i);
      set(i, 1'b1);
      set(i, 1'b0);
   endtask : pulse
   task automatic put(input logic [3:0] v);
      @(posedge clk);
      bufv <= v;
      repeat (6) @(posedge clk);
   endtask : put
endmodule : rcd_station

// ==== bench/reversible_command_counter_decoder_test.sv ====
`timescale 1ns/100ps
module reversible_command_counter_decoder_test;
   import rcd_pkg::*;
   logic ref_clk;
   logic nrst;
   logic [NUM_CTRL-1:0] cmd;
   logic [3:0] bufv;
   logic [3:0] buf_out;
   logic gate_dly;
   rcd_cnt_t count;
   logic dir;
   logic [NUM_CMD-1:0] lines;
   logic [NUM_RELAY-1:0] r_on;
   logic [NUM_RELAY-1:0] r_off;
   logic h_on;
   logic h_off;
   logic d_on;
   logic d_off;
   logic xdcr;
   int fail_count = 0;
   int samples_checked = 0;
   rcd_station i_station (.clk(ref_clk), .cmd(cmd), .bufv(bufv));
   rcd_cmd_top i_dut
   (
      .REF_CLK(ref_clk),
      .NRST(nrst),
      .CMD_UP(cmd[IDX_UP]),
      .CMD_DOWN(cmd[IDX_DOWN]),
      .CMD_EXEC(cmd[IDX_EXEC]),
      .DEC_PWR_ON(cmd[IDX_PWR_ON]),
      .DEC_PWR_OFF(cmd[IDX_PWR_OFF]),
      .HTR_ON(cmd[IDX_HTR_ON]),
      .HTR_OFF(cmd[IDX_HTR_OFF]),
      .STOP_ALL_MOTORS(cmd[IDX_STOP]),
      .DATA_GATE(cmd[IDX_GATE]),
      .BUF_IN(bufv),
      .BUF_OUT(buf_out),
      .DATA_GATE_DLY(gate_dly),
      .COUNT_STATUS(count),
      .DIR_STATUS(dir),
      .LOGIC_CMD_N(lines),
      .RLY_ON_DRV(r_on),
      .RLY_OFF_DRV(r_off),
      .HTR_ON_DRV(h_on),
      .HTR_OFF_DRV(h_off),
      .DEC_ON_DRV(d_on),
      .DEC_OFF_DRV(d_off),
      .PRES_XDCR_ON(xdcr)
   );
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   task automatic test_reset();
      @(posedge ref_clk);
      chk(count, CNT_RST);
      chk(dir, DIR_RST);
      chk(lines, CMD_IDLE_N);
      chk(gate_dly, 1'b0);
      chk(buf_out, 4'h0);
      $display("reset test done");
   endtask : test_reset
   task automatic test_count();
      for (int i = 1; i <= NUM_CMD + 1; i++)
      begin
         i_station.pulse(IDX_UP);
         chk(count, i % NUM_CMD);
      end
      chk(dir, DIR_UP);
      i_station.pulse(IDX_DOWN);
      chk(dir, DIR_DOWN);
      chk(count, 0);
      i_station.pulse(IDX_DOWN);
      chk(count, NUM_CMD - 1);
      i_station.pulse(IDX_PWR_ON);
      chk(count, 0);
      $display("count test done");
   endtask : test_count
   task automatic test_decode();
      logic [31:0] oh;
      for (int k = 0; k < NUM_CMD; k++)
      begin
         oh = 32'h1 << k;
         i_station.set(IDX_EXEC, 1'b1);
         chk(lines, ~oh);
         chk(32'(r_on), DEF_RELAY_MASK[k/2] && k % 2 == 0 ? 32'h1 << k / 2 : 0);
         chk(32'(r_off), DEF_RELAY_MASK[k/2] && k % 2 == 1 ? 32'h1 << k / 2 : 0);
         i_station.set(IDX_EXEC, 1'b0);
         chk(lines, CMD_IDLE_N);
         if (k == DEF_PT_LINE)
            chk(xdcr, 1'b1);
         i_station.pulse(IDX_UP);
      end
      i_station.set(IDX_STOP, 1'b1);
      chk(xdcr, 1'b0);
      i_station.set(IDX_STOP, 1'b0);
      $display("decode test done");
   endtask : test_decode
   task automatic test_direct();
      int pins [4];
      pins = '{IDX_HTR_ON, IDX_HTR_OFF, IDX_PWR_ON, IDX_PWR_OFF};
      i_station.pulse(IDX_UP);
      for (int j = 0; j < 4; j++)
      begin
         i_station.set(pins[j], 1'b1);
         chk({h_on, h_off, d_on, d_off}, 4'h8 >> j);
         i_station.set(pins[j], 1'b0);
      end
      chk(count, 0);
      $display("direct test done");
   endtask : test_direct
   task automatic test_buffers();
      i_station.put(4'hA);
      chk(buf_out, 4'hA);
      i_station.put(4'h5);
      chk(buf_out, 4'h5);
      i_station.set(IDX_GATE, 1'b1);
      chk(gate_dly, 1'b0);
      repeat (3) @(posedge ref_clk);
      chk(gate_dly, 1'b1);
      $display("buffer test done");
   endtask : test_buffers
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      test_done();
   end
   initial
   begin
      nrst = 1'b0;
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      test_reset();
      test_count();
      test_decode();
      test_direct();
      test_buffers();
      test_done();
   end
endmodule : reversible_command_counter_decoder_test
